// file: mpi_top.sv
`include "mpi_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mpi_top
  import mpi_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // option fuses
  input wire logic [7:0] clock_and_irq_option_fuses,
  // cpu side
  input wire logic [10:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic [4:0] region,
  input wire logic insn_done,
  input wire logic irq_mask,
  output logic irq_take,
  input wire logic irq_ack,
  // stack side
  input wire logic call_push,
  input wire logic ret_pull,
  input wire logic [10:0] pc_load,
  input wire logic pc_load_en,
  input wire logic [7:0] index_load,
  input wire logic index_load_en,
  input wire logic [7:0] index_offset_base,
  output logic [10:0] program_counter,
  output logic [7:0] index_ea,
  output logic [10:0] stack_addr,
  output logic stack_busy,
  // pins
  input wire logic irq_pin_b,
  input wire logic [7:0] first_bidir_port_pins_in,
  output logic [7:0] first_bidir_port_pins_out,
  output logic [7:0] first_bidir_port_pins_oe,
  input wire logic [7:0] second_bidir_port_pins_in,
  output logic [7:0] second_bidir_port_pins_out,
  output logic [7:0] second_bidir_port_pins_oe,
  input wire logic [3:0] input_only_port_pins,
  output logic bus_en,
  output logic osc_is_xtal
);
  function automatic logic in_range(input logic [10:0] a, input logic [10:0] lo,
                                    input logic [10:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // bus clock enable: divide by two or four
  logic [1:0] div_ff;
  logic div4;
  assign div4 = clock_and_irq_option_fuses[`MPI_OPT_DIV4_BIT];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_ff <= 2'h0;
    else div_ff <= div_ff + 2'h1;
  end
  assign bus_en = div4 ? (div_ff == 2'h3) : div_ff[0];
  assign osc_is_xtal = clock_and_irq_option_fuses[`MPI_OPT_XTAL_BIT];

  // address decode
  logic sel_io, sel_ram, sel_main, sel_opt, sel_vec;
  logic sel_pa, sel_pb, sel_pc, sel_da, sel_db, sel_tim;
  assign sel_io = cpu_addr <= `MPI_IO_TOP;
  assign sel_ram = in_range(cpu_addr, `MPI_RAM_LO, `MPI_RAM_HI);
  assign sel_main = in_range(cpu_addr, `MPI_MAIN_LO, `MPI_MAIN_HI);
  assign sel_opt = cpu_addr == `MPI_OPT_ADDR;
  assign sel_vec = in_range(cpu_addr, `MPI_VEC_LO, `MPI_VEC_HI);
  assign sel_pa = cpu_addr == `MPI_PORTA_DATA;
  assign sel_pb = cpu_addr == `MPI_PORTB_DATA;
  assign sel_pc = cpu_addr == `MPI_PORTC_DATA;
  assign sel_da = cpu_addr == `MPI_PORTA_DIR;
  assign sel_db = cpu_addr == `MPI_PORTB_DIR;
  assign sel_tim = in_range(cpu_addr, `MPI_TIMER_DATA, `MPI_TIMER_CTRL);
  assign region = {sel_vec | sel_opt, sel_main, sel_ram, sel_io, sel_tim};

  // ports
  logic [7:0] pa_rd, pb_rd, da_rd, db_rd;
  mpi_bidir_port #(.WIDTH(8)) u_port_a (
    .clk(clk), .rst_b(rst_b), .bus_en(bus_en),
    .data_wr(cpu_wr && sel_pa), .dir_wr(cpu_wr && sel_da), .wdata(cpu_wdata),
    .data_rd(pa_rd), .dir_rd(da_rd),
    .pin_in(first_bidir_port_pins_in), .pin_out(first_bidir_port_pins_out),
    .pin_oe(first_bidir_port_pins_oe)
  );
  mpi_bidir_port #(.WIDTH(8)) u_port_b (
    .clk(clk), .rst_b(rst_b), .bus_en(bus_en),
    .data_wr(cpu_wr && sel_pb), .dir_wr(cpu_wr && sel_db), .wdata(cpu_wdata),
    .data_rd(pb_rd), .dir_rd(db_rd),
    .pin_in(second_bidir_port_pins_in), .pin_out(second_bidir_port_pins_out),
    .pin_oe(second_bidir_port_pins_oe)
  );
  // input-only port: no writable state at all, so a write there is dropped
  logic [3:0] pc_meta_ff, pc_sync_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_meta_ff <= 4'h0;
      pc_sync_ff <= 4'h0;
    end else if (bus_en) begin
      pc_meta_ff <= input_only_port_pins;
      pc_sync_ff <= pc_meta_ff;
    end
  end
  logic [7:0] pc_rd;
  assign pc_rd = {`MPI_PORTC_PAD, pc_sync_ff};

  // ram with stack
  logic [7:0] ram [0:`MPI_RAM_WORDS-1];
  logic [5:0] ram_idx;
  logic [7:0] ram_rd_ff;
  assign ram_idx = cpu_addr[5:0];

  // interrupt latch
  logic irq_meta_ff, irq_sync_ff, irq_prev_ff, irq_latch_ff;
  logic level_mode, irq_fall, irq_low, nxt_irq_latch;
  assign level_mode = clock_and_irq_option_fuses[`MPI_OPT_LEVEL_BIT];
  assign irq_fall = irq_prev_ff && !irq_sync_ff;
  assign irq_low = !irq_sync_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_meta_ff <= 1'b1;
      irq_sync_ff <= 1'b1;
      irq_prev_ff <= 1'b1;
    end else if (bus_en) begin
      irq_meta_ff <= irq_pin_b;
      irq_sync_ff <= irq_meta_ff;
      irq_prev_ff <= irq_sync_ff;
    end
  end
  // set wins over acknowledge so a new edge in the ack cycle is kept
  logic irq_set;
  assign irq_set = bus_en && (irq_fall || (level_mode && irq_low));
  assign nxt_irq_latch = irq_set ? 1'b1 : (irq_ack ? 1'b0 : irq_latch_ff);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) irq_latch_ff <= 1'b0;
    else irq_latch_ff <= nxt_irq_latch;
  end
  assign irq_take = insn_done && irq_latch_ff && !irq_mask;

  // core registers
  logic [10:0] pc_ff;
  logic [7:0] x_ff;
  logic [4:0] sp_ff;
  logic [1:0] stk_cnt_ff;
  mpi_stack_op_t stk_op_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) x_ff <= 8'h00;
    else if (index_load_en) x_ff <= index_load;
  end
  assign index_ea = index_offset_base + x_ff;
  assign program_counter = pc_ff;
  assign stack_addr = `MPI_STK_LO | {6'h00, sp_ff};
  assign stack_busy = stk_op_ff != MPI_REG_NONE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_ff <= `MPI_SP_RESET;
      stk_op_ff <= MPI_REG_NONE;
      stk_cnt_ff <= 2'h0;
      pc_ff <= `MPI_VEC_HI - 11'h001;
    end else begin
      case (stk_op_ff)
        MPI_REG_NONE: begin
          if (call_push) begin
            stk_op_ff <= MPI_REG_PUSH;
            stk_cnt_ff <= 2'h0;
          end else if (ret_pull) begin
            stk_op_ff <= MPI_REG_PULL;
            stk_cnt_ff <= 2'h0;
            sp_ff <= sp_ff + 5'h01;
          end else if (pc_load_en) begin
            pc_ff <= pc_load;
          end
        end
        MPI_REG_PUSH: begin
          sp_ff <= sp_ff - 5'h01;
          stk_cnt_ff <= stk_cnt_ff + 2'h1;
          if (stk_cnt_ff == 2'h1) begin
            stk_op_ff <= MPI_REG_NONE;
            if (pc_load_en) pc_ff <= pc_load;
          end
        end
        MPI_REG_PULL: begin
          stk_cnt_ff <= stk_cnt_ff + 2'h1;
          if (stk_cnt_ff == 2'h0) begin
            pc_ff[10:8] <= ram[{1'b1, sp_ff}][2:0];
            sp_ff <= sp_ff + 5'h01;
          end else begin
            pc_ff[7:0] <= ram[{1'b1, sp_ff}];
            stk_op_ff <= MPI_REG_NONE;
          end
        end
        default: stk_op_ff <= MPI_REG_NONE;
      endcase
    end
  end

  logic push_wr;
  logic [7:0] push_data;
  assign push_wr = stk_op_ff == MPI_REG_PUSH;
  assign push_data = (stk_cnt_ff == 2'h0) ? pc_ff[7:0] : (pc_ff[10:8] & `MPI_PCH_MASK);
  always_ff @(posedge clk) begin
    if (push_wr) ram[{1'b1, sp_ff}] <= push_data;
    else if (cpu_wr && sel_ram) ram[ram_idx] <= cpu_wdata;
    ram_rd_ff <= ram[ram_idx];
  end

  // read data
  logic [7:0] nxt_rdata, rdata_ff;
  assign nxt_rdata = sel_pa ? pa_rd :
                     sel_pb ? pb_rd :
                     sel_pc ? pc_rd :
                     sel_da ? da_rd :
                     sel_db ? db_rd :
                     sel_opt ? clock_and_irq_option_fuses : 8'h00;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rdata_ff <= 8'h00;
    else if (cpu_rd) rdata_ff <= nxt_rdata;
  end
  assign cpu_rdata = sel_ram ? ram_rd_ff : rdata_ff;

  // request latch: an ack and a new request may meet, and the request must win
  AST_IRQ_TAKE: assert property (@(posedge clk) disable iff (!rst_b)
    (insn_done && irq_latch_ff && irq_mask) |-> !irq_take)
    else $error("interrupt taken while masked");
  AST_IRQ_GO: assert property (@(posedge clk) disable iff (!rst_b)
    (insn_done && irq_latch_ff && !irq_mask) |-> irq_take)
    else $error("unmasked request not taken");
  AST_IRQ_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    (!insn_done || !irq_latch_ff) |-> !irq_take)
    else $error("interrupt taken without request or instruction end");
  AST_IRQ_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_latch_ff && !irq_ack) |=> irq_latch_ff)
    else $error("pending request lost");
  AST_IRQ_ACK: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_ack && !irq_set) |=> !irq_latch_ff)
    else $error("acknowledge did not clear request");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (!rst_b)
    irq_set |=> irq_latch_ff)
    else $error("request not latched");
  AST_LEVEL_SET: assert property (@(posedge clk) disable iff (!rst_b)
    (level_mode && bus_en && irq_low) |=> irq_latch_ff)
    else $error("low level did not request in level mode");
  AST_EDGE_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
    (!level_mode && !irq_latch_ff && bus_en && !irq_fall) |=> !irq_latch_ff)
    else $error("level caused request in edge mode");
  AST_IRQ_RESET: assert property (@(posedge clk) $rose(rst_b) |-> !irq_latch_ff)
    else $error("latch not cleared by reset");

  // reset presets, address map and read data
  AST_CORE_RESET: assert property (@(posedge clk) $rose(rst_b) |->
    (program_counter == `MPI_VEC_HI - 11'h001 && stack_addr == `MPI_RAM_HI))
    else $error("core registers not preset by reset");
  AST_PC_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    (stk_op_ff == MPI_REG_NONE && !call_push && !ret_pull && pc_load_en)
      |=> program_counter == $past(pc_load))
    else $error("program counter load lost");
  AST_X_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    index_load_en |=> x_ff == $past(index_load))
    else $error("index register load lost");
  AST_PORTC: assert property (@(posedge clk) sel_pc |-> nxt_rdata[7:4] == 4'hf)
    else $error("input port upper bits not one");
  AST_REGION_ONE: assert property (@(posedge clk) $onehot0(region[4:1]))
    else $error("address decodes to two regions");
  AST_OPT_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_rd && sel_opt) |=> rdata_ff == $past(clock_and_irq_option_fuses))
    else $error("option register read wrong");
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_rd && !sel_io && !sel_opt) |=> rdata_ff == 8'h00)
    else $error("read outside the register block not zero");

  // ram and stack: a cpu write to ram in a push cycle is dropped, the push has priority
  AST_RAM_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (cpu_wr && sel_ram && !push_wr) |=> ram[$past(ram_idx)] == $past(cpu_wdata))
    else $error("ram write lost");
  AST_STACK_RANGE: assert property (@(posedge clk)
    stack_addr >= `MPI_STK_LO && stack_addr <= `MPI_RAM_HI)
    else $error("stack pointer outside its region");
  AST_PUSH_TWO: assert property (@(posedge clk) disable iff (!rst_b)
    (stk_op_ff == MPI_REG_NONE && call_push) |=> ##1 (stk_op_ff == MPI_REG_PUSH)
      ##1 (stk_op_ff == MPI_REG_NONE && sp_ff == $past(sp_ff, 2) - 5'h02))
    else $error("call did not push two bytes");
  AST_PUSH_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    (stk_op_ff == MPI_REG_NONE && call_push) |=> ##2
      (ram[{1'b1, $past(sp_ff, 3)}] == $past(pc_ff[7:0], 3)))
    else $error("low pc byte not stacked first");
  AST_PUSH_HIGH: assert property (@(posedge clk) disable iff (!rst_b)
    (stk_op_ff == MPI_REG_NONE && call_push) |=> ##2
      (ram[{1'b1, $past(sp_ff, 3) - 5'h01}] == {5'h00, $past(pc_ff[10:8], 3)}))
    else $error("upper pc bits not stacked second");
  AST_PULL_TWO: assert property (@(posedge clk) disable iff (!rst_b)
    (stk_op_ff == MPI_REG_NONE && !call_push && ret_pull)
      |=> (stk_op_ff == MPI_REG_PULL)
      ##1 (stk_op_ff == MPI_REG_PULL)
      ##1 (stk_op_ff == MPI_REG_NONE && sp_ff == $past(sp_ff, 3) + 5'h02))
    else $error("return did not pull two bytes");

  // bus enable divider
  AST_BUS_DIV: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_en && !div4) |=> !bus_en ##1 bus_en)
    else $error("divide by two enable wrong");
  AST_BUS_DIV4: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_en && div4) |=> !bus_en ##1 !bus_en ##1 !bus_en ##1 bus_en)
    else $error("divide by four enable wrong");
endmodule // mpi_top
`default_nettype wire

// file: mpi_defines.svh
// Notes on behaviour
// - interrupt sensing selectable: falling edge only, or falling edge plus low level
// - interrupt line low for one bus cycle sets the request latch
// - at instruction end, take interrupt only if latch set and mask clear
// - bus clock is oscillator divided by two or four, chosen by option bit
// - option register also selects crystal or resistor oscillator
// - direction bit one makes a pin output, zero makes it input
// - any reset clears all direction bits so pins start as inputs
// - output pin drives its port output data latch bit
// - two bidirectional ports, eight pins each, direction per pin
// - input-only port reads four pin levels, upper four bits read one
// - program counter addresses 2048 byte locations
// - main program memory decodes from 080 through 4b6 inclusive
// - vectors at 7f6 to 7ff, option register at 7f5
// - seven of lowest sixteen addresses decode to ports, directions and timer
// - RAM is 64 bytes, up to 32 of them stack
// - push decrements pointer, low pc byte first then upper three bits
// - pull increments pointer, restoring in reverse push order
// - subroutine call pushes only the two program counter bytes
// - program counter is an 11-bit register of next instruction address
// - index register is 8 bits and supplies indexed address offset
// - writes update latch; reads give pin for inputs, latch for outputs
// - masked request stays latched until mask is cleared
// - any reset clears the external interrupt request latch
`ifndef MPI_DEFINES_SVH
`define MPI_DEFINES_SVH
`define MPI_ADDR_W 11
`define MPI_PORTA_DATA 11'h000
`define MPI_PORTB_DATA 11'h001
`define MPI_PORTC_DATA 11'h002
`define MPI_PORTA_DIR 11'h004
`define MPI_PORTB_DIR 11'h005
`define MPI_TIMER_DATA 11'h008
`define MPI_TIMER_CTRL 11'h009
`define MPI_IO_TOP 11'h00f
`define MPI_RAM_LO 11'h040
`define MPI_RAM_HI 11'h07f
`define MPI_STK_LO 11'h060
`define MPI_MAIN_LO 11'h080
`define MPI_MAIN_HI 11'h4b6
`define MPI_OPT_ADDR 11'h7f5
`define MPI_VEC_LO 11'h7f6
`define MPI_VEC_HI 11'h7ff
`define MPI_SP_RESET 5'h1f
`define MPI_PCH_MASK 8'h07
`define MPI_PORTC_PAD 4'hf
`define MPI_OPT_DIV4_BIT 0
`define MPI_OPT_LEVEL_BIT 1
`define MPI_OPT_XTAL_BIT 2
`define MPI_RAM_WORDS 64
`endif

// file: mpi_pkg.sv
`default_nettype none
package mpi_pkg;
  typedef enum logic [1:0] {
    MPI_REG_NONE,
    MPI_REG_PUSH,
    MPI_REG_PULL
  } mpi_stack_op_t;
  typedef enum logic [2:0] {
    MPI_REGION_NONE,
    MPI_REGION_IO,
    MPI_REGION_RAM,
    MPI_REGION_MAIN,
    MPI_REGION_OPT,
    MPI_REGION_VEC
  } mpi_region_t;
endpackage
`default_nettype wire

// file: mpi_bidir_port.sv
`timescale 1ns/1ps
`default_nettype none
module mpi_bidir_port #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_en,
  // register access
  input wire logic data_wr,
  input wire logic dir_wr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] data_rd,
  output logic [WIDTH-1:0] dir_rd,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("port width must be 1 to 8");
  end
  logic [WIDTH-1:0] latch_ff;
  logic [WIDTH-1:0] dir_ff;
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  // data latch is not reset: direction bits and the input synchroniser are cleared by reset
  always_ff @(posedge clk) begin
    if (bus_en && data_wr) latch_ff <= wdata;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_ff <= '0;
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (bus_en) begin
      if (dir_wr) dir_ff <= wdata;
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      assign pin_oe[g] = dir_ff[g];
      assign pin_out[g] = latch_ff[g];
      assign data_rd[g] = dir_ff[g] ? latch_ff[g] : sync_ff[g];
    end
  endgenerate
  assign dir_rd = dir_ff;
  AST_DIR_RESET: assert property (@(posedge clk) $rose(rst_b) |-> pin_oe == '0)
    else $error("direction not cleared by reset");
  AST_OUT_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_en && data_wr) |=> pin_out == $past(wdata))
    else $error("output pin does not drive latch");
  AST_DIR_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (bus_en && dir_wr) |=> pin_oe == $past(wdata))
    else $error("direction write not applied to pin enables");
endmodule // mpi_bidir_port
`default_nettype wire

// file: mpi_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module mpi_periph_model (
  // first port
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] a_ext,
  output logic [7:0] a_pin,
  // second port
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_ext,
  output logic [7:0] b_pin,
  // interrupt line
  input wire logic irq_pull_low,
  output logic irq_pin_b
);
  // a driven pin shows the device latch, an undriven one the peripheral level
  assign a_pin = (a_oe & a_out) | (~a_oe & a_ext);
  assign b_pin = (b_oe & b_out) | (~b_oe & b_ext);
  // open-drain source on a pulled-up line: released reads high
  assign irq_pin_b = ~irq_pull_low;
endmodule // mpi_periph_model
`default_nettype wire

// file: mcu_ports_irq_memory_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_ports_irq_memory_map_tb_top;
  import mpi_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic [7:0] fuses = 8'h04;
  logic [10:0] addr = '0;
  logic [10:0] pc_load = '0;
  logic wr = 0, rd = 0, insn_done = 0, irq_mask = 1, irq_ack = 0;
  logic call_push = 0, ret_pull = 0, pc_load_en = 0, irq_low = 0;
  logic [7:0] wdata = '0, a_ext = 8'h3c, b_ext = 8'hc3;
  logic [7:0] x_load = '0, x_base = '0, ea;
  logic x_load_en = 0;
  logic [7:0] rdata, a_pin, b_pin, a_out, a_oe, b_out, b_oe;
  logic [3:0] c_pins = 4'h6;
  logic [4:0] region;
  logic [10:0] pc, stack_addr;
  logic irq_pin_b, irq_take, bus_en, xtal, stack_busy;
  int error_cnt = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  mpi_top i_dut (.clk(clk), .rst_b(rst_b), .clock_and_irq_option_fuses(fuses),
    .cpu_addr(addr), .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wdata), .cpu_rdata(rdata),
    .region(region), .insn_done(insn_done), .irq_mask(irq_mask), .irq_take(irq_take),
    .irq_ack(irq_ack), .call_push(call_push), .ret_pull(ret_pull), .pc_load(pc_load),
    .pc_load_en(pc_load_en), .index_load(x_load), .index_load_en(x_load_en),
    .index_offset_base(x_base), .program_counter(pc), .index_ea(ea),
    .stack_addr(stack_addr), .stack_busy(stack_busy), .irq_pin_b(irq_pin_b),
    .first_bidir_port_pins_in(a_pin), .first_bidir_port_pins_out(a_out),
    .first_bidir_port_pins_oe(a_oe), .second_bidir_port_pins_in(b_pin),
    .second_bidir_port_pins_out(b_out), .second_bidir_port_pins_oe(b_oe),
    .input_only_port_pins(c_pins), .bus_en(bus_en), .osc_is_xtal(xtal));
  mpi_periph_model i_periph (.a_out(a_out), .a_oe(a_oe), .a_ext(a_ext), .a_pin(a_pin),
    .b_out(b_out), .b_oe(b_oe), .b_ext(b_ext), .b_pin(b_pin),
    .irq_pull_low(irq_low), .irq_pin_b(irq_pin_b));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // a port or direction write is taken only at an edge where the bus enable is high
  task automatic wait_en();
    int n;
    n = 0;
    while (bus_en !== 1'b1 && n < 16) begin
      tick(1);
      n++;
    end
    chk(bus_en, 1'b1, "bus enable seen");
    tick(1);
  endtask
  task automatic bus_wr(input logic [10:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    wait_en();
    wr = 0;
    tick(1);
  endtask
  task automatic bus_rd(input logic [10:0] a, input logic [7:0] exp, input string what);
    addr = a;
    rd = 1;
    wait_en();
    rd = 0;
    tick(1);
    chk(rdata, exp, what);
  endtask
  task automatic do_reset(input logic [7:0] f);
    rst_b = 0;
    fuses = f;
    tick(16);
    rst_b = 1;
  endtask
  // irq_take is combinational, so it is looked at while insn_done is up
  task automatic insn(input logic exp, input string what);
    insn_done = 1;
    #1;
    chk(irq_take, exp, what);
    tick(1);
    insn_done = 0;
    tick(1);
  endtask
  task automatic ack();
    irq_ack = 1;
    tick(1);
    irq_ack = 0;
  endtask
  task automatic count_en(input int exp);
    int n;
    n = 0;
    repeat (16) begin
      tick(1);
      if (bus_en === 1'b1) n++;
    end
    chk(n, exp, "bus enable rate");
  endtask
  task automatic stack_op(input logic push);
    int n;
    call_push = push;
    ret_pull = ~push;
    tick(1);
    chk(stack_busy, 1'b1, "stack busy");
    call_push = 0;
    ret_pull = 0;
    n = 0;
    while (stack_busy !== 1'b0 && n < 8) begin
      tick(1);
      n++;
    end
    chk(n, 2, "stack cycles");
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #(50 * 6000);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    logic [10:0] ra [8];
    logic [4:0] re [8];
    ra = '{11'h000, 11'h040, 11'h07f, 11'h080, 11'h4b6, 11'h4b7, 11'h7f5, 11'h7ff};
    re = '{5'h02, 5'h04, 5'h04, 5'h08, 5'h08, 5'h00, 5'h10, 5'h10};
    do_reset(8'h04);
    chk(a_oe, 8'h00, "dir a reset");
    chk(b_oe, 8'h00, "dir b reset");
    chk(pc, 11'h7fe, "pc reset");
    chk(stack_addr, 11'h07f, "sp reset");
    chk(xtal, 1'b1, "crystal");
    count_en(8);
    $display("test reset done");
    bus_wr(11'h000, 8'ha5);
    bus_wr(11'h004, 8'hf0);
    bus_wr(11'h001, 8'h5a);
    bus_wr(11'h005, 8'h0f);
    chk(a_oe, 8'hf0, "dir a");
    chk(b_oe, 8'h0f, "dir b");
    chk(a_out & a_oe, 8'ha0, "latch a");
    chk(b_out & b_oe, 8'h0a, "latch b");
    bus_wr(11'h002, 8'h00);
    bus_rd(11'h000, 8'hac, "read a");
    bus_rd(11'h001, 8'hca, "read b");
    bus_rd(11'h002, 8'hf6, "read c");
    bus_rd(11'h7f5, 8'h04, "option");
    bus_wr(11'h050, 8'h9c);
    bus_rd(11'h050, 8'h9c, "ram");
    for (int i = 0; i < 8; i++) begin
      addr = ra[i];
      tick(1);
      chk(region, re[i], "region");
    end
    $display("test ports and map done");
    pc_load = 11'h5a3;
    pc_load_en = 1;
    tick(1);
    pc_load_en = 0;
    stack_op(1'b1);
    chk(stack_addr, 11'h07d, "sp after push");
    bus_rd(11'h07f, 8'ha3, "stacked low");
    bus_rd(11'h07e, 8'h05, "stacked high");
    pc_load = 11'h000;
    pc_load_en = 1;
    tick(1);
    pc_load_en = 0;
    stack_op(1'b0);
    chk(pc, 11'h5a3, "pc after pull");
    chk(stack_addr, 11'h07f, "sp after pull");
    x_load = 8'h35;
    x_base = 8'h40;
    x_load_en = 1;
    tick(1);
    x_load_en = 0;
    chk(ea, 8'h75, "index ea");
    $display("test stack done");
    irq_low = 1;
    tick(24);
    insn(1'b0, "masked");
    irq_mask = 0;
    insn(1'b1, "unmasked");
    ack();
    tick(24);
    insn(1'b0, "edge only");
    irq_low = 0;
    tick(100); // keep requests well apart
    irq_low = 1;
    tick(24);
    irq_low = 0;
    do_reset(8'h03);
    chk(xtal, 1'b0, "resistor osc");
    count_en(4);
    insn(1'b0, "latch after reset");
    irq_low = 1;
    tick(24);
    insn(1'b1, "level request");
    ack();
    tick(24);
    insn(1'b1, "level relatch");
    irq_low = 0;
    $display("test interrupt done");
    results();
  end
endmodule // mcu_ports_irq_memory_map_tb_top
`default_nettype wire
